/* File: inc/synth_divider_vco_band_regs.vh */
// Offsets, field positions, reset values and frame layout of the synthesizer register bank
`ifndef SYNTH_DIVIDER_VCO_BAND_REGS_VH
`define SYNTH_DIVIDER_VCO_BAND_REGS_VH

// ****************************************
// Main bank offsets (bank select = 0)
// ****************************************
`define BANK_CTRL_ADDR 5'h00
`define FRAC_WORD_LOW_ADDR 5'h1a
`define FRAC_WORD_HIGH_ADDR 5'h1b
`define INT_DIVIDE_CTRL_ADDR 5'h1c
`define OSC_TUNE_ADDR 5'h1d
`define LO_VCO_BAND_CTRL_ADDR 5'h1e

// ****************************************
// Local bank offsets (bank select = 1)
// ****************************************
`define OSC_DAC_CTRL_ADDR 5'h09
`define READOUT_CTRL_ADDR 5'h10

// ****************************************
// Field positions
// ****************************************
`define BANK_SEL_BIT 9
`define TRIG_EN_BIT 9
`define INT_RATIO_MSB 8
`define OSC_TUNE_MSB 7
`define DAC_CURRENT_MSB 5
`define OSC_DAC_EN_BIT 8
`define READOUT_SEL_BIT 9
`define LO_BAND_MSB 9
`define LO_BAND_LSB 8
`define RELOCK_SEL_BIT 7
`define BAND_SRC_BIT 6
`define BAND_OVR_MSB 5
`define ADC_RESULT_MSB 8
`define ADC_RESULT_LSB 6

// ****************************************
// Reset values
// ****************************************
`define FRAC_HALF_RST 10'h155
`define INT_DIVIDE_CTRL_RST 10'h274
`define OSC_TUNE_RST 10'h000
`define LO_VCO_BAND_CTRL_RST 10'h15f
`define BANK_SEL_RST 1'b0
`define OSC_DAC_EN_RST 1'b0
`define READOUT_SEL_RST 1'b0

// ****************************************
// Serial frame: read flag, 5 address bits, 10 data bits, MSB first
// ****************************************
`define FRAME_BITS 5'd16
`define HEADER_BITS 5'd6
`define DATA_BITS 10

`endif

/* File: rtl/pin_sync_edge.v */
// Two-stage pin synchroniser with rise and fall detection per bit
`timescale 1ns/10ps
module pin_sync_edge #(
	parameter W = 3
) (
	input wire mclk,
	input wire reset_n,
	input wire [W-1:0] pin_in,
	output wire [W-1:0] level,
	output wire [W-1:0] rise,
	output wire [W-1:0] fall
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_r;
			reg sync_r;
			reg prev_r;
			// First stage feeds only the second stage
			always @(posedge mclk) begin
				if (!reset_n) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
					prev_r <= 1'b1;
				end else begin
					meta_r <= pin_in[i];
					sync_r <= meta_r;
					prev_r <= sync_r;
				end
			end
			assign level[i] = sync_r;
			assign rise[i] = sync_r & ~prev_r;
			assign fall[i] = ~sync_r & prev_r;
		end
	endgenerate
endmodule // pin_sync_edge

/* File: rtl/synth_divider_vco_band_regs.v */
// Serial-programmed synthesizer divider, crystal tuning and VCO band register bank
`timescale 1ns/10ps
`include "synth_divider_vco_band_regs.vh"
module synth_divider_vco_band_regs (
	input wire mclk,
	input wire reset_n,
	input wire sclk,
	input wire cs_n,
	input wire din,
	output reg dout,
	output wire dout_oe,
	input wire [2:0] autoselect_adc_result,
	input wire [5:0] vco_band_switch,
	output wire [19:0] frac_divide_word,
	output wire [8:0] int_divide_ratio,
	output wire autoselect_trigger_en,
	output reg autoselect_start,
	output wire osc_dac_en,
	output wire [7:0] osc_tune_code,
	output wire [5:0] dac_current_code,
	output wire [1:0] lo_sub_band,
	output wire relock_start_sel,
	output wire band_source_sel,
	output wire [5:0] band_override,
	output reg [5:0] vco_band_sel,
	output wire bank_sel,
	output wire band_readout_sel
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	wire [2:0] pin_level;
	wire [2:0] pin_rise;
	wire [2:0] pin_fall;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_level;
	wire cs_fall;
	wire cs_rise;
	wire din_level;

	pin_sync_edge #(
		.W(3)
	) u_pin_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.pin_in({din, cs_n, sclk}),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// Synchroniser comes out of reset high, so an idle-low serial clock
	// shows one false fall; serial clock edges are only used inside a frame.
	assign sclk_rise = pin_rise[0];
	assign sclk_fall = pin_fall[0];
	assign cs_level = pin_level[1];
	assign cs_fall = pin_fall[1];
	assign cs_rise = pin_rise[1];
	assign din_level = pin_level[2];

	// ****************************************
	// Serial frame shifter
	// ****************************************
	reg [4:0] bit_cnt_r;
	reg [15:0] shift_r;
	reg [9:0] dout_shift_r;
	reg read_r;
	reg [4:0] addr_r;
	wire [15:0] shift_nxt;
	wire header_done;
	wire frame_done;

	assign shift_nxt = {shift_r[14:0], din_level};
	assign header_done = sclk_rise && !cs_level && (bit_cnt_r == `HEADER_BITS - 5'd1);
	assign frame_done = sclk_rise && !cs_level && (bit_cnt_r == `FRAME_BITS - 5'd1);
	// Only drive the data pin while the frame is selected
	assign dout_oe = ~cs_level;

	always @(posedge mclk) begin
		if (!reset_n) begin
			bit_cnt_r <= 5'h00;
			shift_r <= 16'h0000;
			read_r <= 1'b0;
			addr_r <= 5'h00;
		end else if (cs_fall) begin
			bit_cnt_r <= 5'h00;
		end else if (sclk_rise && !cs_level) begin
			shift_r <= shift_nxt;
			// Clocks past the frame length are ignored
			if (bit_cnt_r != `FRAME_BITS)
				bit_cnt_r <= bit_cnt_r + 5'd1;
			if (header_done) begin
				read_r <= shift_nxt[5];
				addr_r <= shift_nxt[4:0];
			end
		end
	end

	// ****************************************
	// Register storage
	// ****************************************
	reg [9:0] frac_low_r;
	reg [9:0] frac_high_r;
	reg [9:0] int_ctrl_r;
	reg [9:0] frac_low_act_r;
	reg [9:0] frac_high_act_r;
	reg [9:0] int_ctrl_act_r;
	reg [9:0] osc_tune_r;
	reg [9:0] band_ctrl_r;
	reg bank_sel_r;
	reg osc_dac_en_r;
	reg readout_sel_r;
	reg commit_pend_r;
	wire wr_en;
	wire [4:0] wr_addr;
	wire [9:0] wr_data;
	wire main_sel;

	assign wr_en = frame_done && !read_r;
	assign wr_addr = addr_r;
	assign wr_data = shift_nxt[9:0];
	assign main_sel = !bank_sel_r;

	always @(posedge mclk) begin
		if (!reset_n) begin
			frac_low_r <= `FRAC_HALF_RST;
			frac_high_r <= `FRAC_HALF_RST;
			int_ctrl_r <= `INT_DIVIDE_CTRL_RST;
			osc_tune_r <= `OSC_TUNE_RST;
			band_ctrl_r <= `LO_VCO_BAND_CTRL_RST;
			bank_sel_r <= `BANK_SEL_RST;
			osc_dac_en_r <= `OSC_DAC_EN_RST;
			readout_sel_r <= `READOUT_SEL_RST;
		end else if (wr_en) begin
			// Bank select lives at address 0 of both banks
			if (wr_addr == `BANK_CTRL_ADDR)
				bank_sel_r <= wr_data[`BANK_SEL_BIT];
			if (main_sel) begin
				case (wr_addr)
					`FRAC_WORD_LOW_ADDR: frac_low_r <= wr_data;
					`FRAC_WORD_HIGH_ADDR: frac_high_r <= wr_data;
					`INT_DIVIDE_CTRL_ADDR: int_ctrl_r <= wr_data;
					`OSC_TUNE_ADDR: osc_tune_r <= wr_data;
					`LO_VCO_BAND_CTRL_ADDR: band_ctrl_r <= wr_data;
					default: ;
				endcase
			end else begin
				case (wr_addr)
					`OSC_DAC_CTRL_ADDR: osc_dac_en_r <= wr_data[`OSC_DAC_EN_BIT];
					`READOUT_CTRL_ADDR: readout_sel_r <= wr_data[`READOUT_SEL_BIT];
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Divider commit and autoselect start
	// ****************************************
	// Committing on chip-select release keeps the synthesizer from
	// ever seeing a half-updated integer and fractional pair.
	wire frac_low_wr;
	wire commit_now;

	assign frac_low_wr = wr_en && main_sel && (wr_addr == `FRAC_WORD_LOW_ADDR);
	// Pending flag carries the low-half write up to the end of its own frame
	assign commit_now = cs_rise && commit_pend_r;

	always @(posedge mclk) begin
		if (!reset_n) begin
			commit_pend_r <= 1'b0;
			frac_low_act_r <= `FRAC_HALF_RST;
			frac_high_act_r <= `FRAC_HALF_RST;
			int_ctrl_act_r <= `INT_DIVIDE_CTRL_RST;
			autoselect_start <= 1'b0;
		end else begin
			autoselect_start <= 1'b0;
			if (cs_fall)
				commit_pend_r <= 1'b0;
			else if (frac_low_wr)
				commit_pend_r <= 1'b1;
			if (commit_now) begin
				commit_pend_r <= 1'b0;
				frac_low_act_r <= frac_low_r;
				frac_high_act_r <= frac_high_r;
				int_ctrl_act_r <= int_ctrl_r;
				// Newly committed enable decides, as host wrote 28 first
				autoselect_start <= int_ctrl_r[`TRIG_EN_BIT];
			end
		end
	end

	// ****************************************
	// Active divider outputs
	// ****************************************
	assign frac_divide_word = {frac_high_act_r, frac_low_act_r};
	assign int_divide_ratio = int_ctrl_act_r[`INT_RATIO_MSB:0];
	assign autoselect_trigger_en = int_ctrl_act_r[`TRIG_EN_BIT];

	// ****************************************
	// Oscillator tuning and VCO band control
	// ****************************************
	assign osc_dac_en = osc_dac_en_r;
	// Tune code is meaningful only while the DAC is off
	assign osc_tune_code = osc_dac_en_r ? 8'h00 : osc_tune_r[`OSC_TUNE_MSB:0];
	// Upper two bits of the field are ignored in DAC mode
	assign dac_current_code = osc_dac_en_r ? osc_tune_r[`DAC_CURRENT_MSB:0] : 6'h00;
	assign lo_sub_band = band_ctrl_r[`LO_BAND_MSB:`LO_BAND_LSB];
	assign relock_start_sel = band_ctrl_r[`RELOCK_SEL_BIT];
	assign band_source_sel = band_ctrl_r[`BAND_SRC_BIT];
	assign band_override = band_ctrl_r[`BAND_OVR_MSB:0];
	assign bank_sel = bank_sel_r;
	assign band_readout_sel = readout_sel_r;

	// Override field of the address 30 reset pattern, cut to the band width
	wire [9:0] band_ctrl_rst;
	assign band_ctrl_rst = `LO_VCO_BAND_CTRL_RST;

	always @(posedge mclk) begin
		if (!reset_n)
			vco_band_sel <= band_ctrl_rst[`BAND_OVR_MSB:0];
		else if (band_source_sel)
			vco_band_sel <= vco_band_switch;
		else
			vco_band_sel <= band_override;
	end

	// ****************************************
	// Readback
	// ****************************************
	reg [9:0] rd_data;

	always @* begin
		rd_data = 10'h000;
		if (addr_r == `BANK_CTRL_ADDR)
			rd_data[`BANK_SEL_BIT] = bank_sel_r;
		else if (main_sel) begin
			case (addr_r)
				`FRAC_WORD_LOW_ADDR: rd_data = frac_low_r;
				`FRAC_WORD_HIGH_ADDR: rd_data = frac_high_r;
				`INT_DIVIDE_CTRL_ADDR: rd_data = int_ctrl_r;
				`OSC_TUNE_ADDR: rd_data = osc_tune_r;
				`LO_VCO_BAND_CTRL_ADDR: begin
					if (readout_sel_r) begin
						rd_data[`ADC_RESULT_MSB:`ADC_RESULT_LSB] = autoselect_adc_result;
						rd_data[`BAND_OVR_MSB:0] = vco_band_switch;
					end else begin
						rd_data = band_ctrl_r;
					end
				end
				default: rd_data = 10'h000;
			endcase
		end else begin
			case (addr_r)
				`OSC_DAC_CTRL_ADDR: rd_data[`OSC_DAC_EN_BIT] = osc_dac_en_r;
				`READOUT_CTRL_ADDR: rd_data[`READOUT_SEL_BIT] = readout_sel_r;
				default: rd_data = 10'h000;
			endcase
		end
	end

	// Data shifts out on falling serial clock so it is stable at the next rise
	wire rd_first_bit;
	wire rd_next_bit;

	assign rd_first_bit = sclk_fall && read_r && (bit_cnt_r == `HEADER_BITS);
	assign rd_next_bit = sclk_fall && read_r && (bit_cnt_r > `HEADER_BITS);

	always @(posedge mclk) begin
		if (!reset_n) begin
			dout <= 1'b0;
			dout_shift_r <= 10'h000;
		end else if (cs_level) begin
			dout <= 1'b0;
		end else if (rd_first_bit) begin
			dout <= rd_data[`DATA_BITS-1];
			dout_shift_r <= {rd_data[`DATA_BITS-2:0], 1'b0};
		end else if (rd_next_bit) begin
			dout <= dout_shift_r[`DATA_BITS-1];
			dout_shift_r <= {dout_shift_r[`DATA_BITS-2:0], 1'b0};
		end
	end

endmodule // synth_divider_vco_band_regs

/* File: verif/host_model.sv */
// Host controller model driving the serial register link
`timescale 1ns/10ps
module host_model (
	input wire mclk,
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire dout
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// 400 ns serial clock; read bits taken late in the high phase for margin
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [9:0] d, output logic [9:0] q);
		logic [15:0] f;
		f = {rd, a, d};
		q = 10'h000;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = f[i];
			wait_n(4);
			sclk = 1'b1;
			wait_n(4);
			if (i < 10)
				q[i] = dout;
			sclk = 1'b0;
		end
		// Released line shows no stale value
		din = ~din;
		wait_n(2);
		cs_n = 1'b1;
		wait_n(6);
	endtask
endmodule // host_model

/* File: verif/regs_properties.sv */
// Concurrent checks on the synthesizer register bank ports
`timescale 1ns/10ps
module regs_properties (
	input wire mclk,
	input wire reset_n,
	input wire cs_n,
	input wire dout,
	input wire dout_oe,
	input wire [5:0] vco_band_switch,
	input wire [19:0] frac_divide_word,
	input wire [8:0] int_divide_ratio,
	input wire autoselect_trigger_en,
	input wire autoselect_start,
	input wire osc_dac_en,
	input wire [7:0] osc_tune_code,
	input wire [5:0] dac_current_code,
	input wire [1:0] lo_sub_band,
	input wire relock_start_sel,
	input wire band_source_sel,
	input wire [5:0] band_override,
	input wire [5:0] vco_band_sel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_cs_idle;
		cs_n [*4];
	endsequence
	sequence s_pulse;
		autoselect_start ##1 !autoselect_start;
	endsequence
	property p_start_single;
		$rose(autoselect_start) |-> s_pulse;
	endproperty
	property p_start_commit;
		autoselect_start |-> autoselect_trigger_en && cs_n && !dout_oe;
	endproperty
	// Active values may only move after the select is released
	property p_commit_cs;
		!$stable({frac_divide_word, int_divide_ratio, autoselect_trigger_en}) |-> cs_n && !dout_oe;
	endproperty
	property p_band_sel;
		$past(reset_n) |-> vco_band_sel == $past(band_source_sel ? vco_band_switch : band_override);
	endproperty
	property p_osc_tune;
		osc_dac_en |-> osc_tune_code == 8'h00;
	endproperty
	property p_dac_cur;
		!osc_dac_en |-> dac_current_code == 6'h00;
	endproperty
	property p_oe_idle;
		s_cs_idle |-> !dout_oe && !dout;
	endproperty
	property p_reset_vals;
		$rose(reset_n) |-> frac_divide_word == 20'h55555 && int_divide_ratio == 9'h074 && autoselect_trigger_en
			&& lo_sub_band == 2'h1 && !relock_start_sel && band_source_sel && band_override == 6'h1f
			&& osc_tune_code == 8'h00;
	endproperty
	a_start_single: assert property (p_start_single) else $error("start pulse too long");
	a_start_commit: assert property (p_start_commit) else $error("start pulse out of place");
	a_commit_cs: assert property (p_commit_cs) else $error("commit while selected");
	a_band_sel: assert property (p_band_sel) else $error("band source mux wrong");
	a_osc_tune: assert property (p_osc_tune) else $error("tune code in current mode");
	a_dac_cur: assert property (p_dac_cur) else $error("current code in tune mode");
	a_oe_idle: assert property (p_oe_idle) else $error("serial out active when idle");
	a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");
endmodule // regs_properties

/* File: verif/tb.sv */
// Self-checking testbench for the synthesizer register bank
`timescale 1ns/10ps
module tb;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic sclk, cs_n, din, dout, dout_oe, autoselect_trigger_en, autoselect_start, osc_dac_en;
	logic relock_start_sel, band_source_sel, bank_sel, band_readout_sel;
	logic [2:0] autoselect_adc_result = 3'h0;
	logic [5:0] vco_band_switch = 6'h00;
	logic [5:0] dac_current_code, band_override, vco_band_sel;
	logic [19:0] frac_divide_word;
	logic [8:0] int_divide_ratio;
	logic [7:0] osc_tune_code;
	logic [1:0] lo_sub_band;
	logic dout_line;
	int n_fail = 0;
	int checked = 0;
	int n_start = 0;
	int s;
	always #25 mclk = ~mclk;
	// Deselected output line reads as the inverse of its last value
	assign dout_line = dout_oe ? dout : ~dout;
	host_model host (.mclk, .sclk, .cs_n, .din, .dout(dout_line));
	synth_divider_vco_band_regs DUT (.mclk, .reset_n, .sclk, .cs_n, .din, .dout, .dout_oe,
		.autoselect_adc_result, .vco_band_switch, .frac_divide_word, .int_divide_ratio,
		.autoselect_trigger_en, .autoselect_start, .osc_dac_en, .osc_tune_code, .dac_current_code,
		.lo_sub_band, .relock_start_sel, .band_source_sel, .band_override, .vco_band_sel, .bank_sel,
		.band_readout_sel);
	always @(posedge mclk)
		if (autoselect_start === 1'b1)
			n_start <= n_start + 1;
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [9:0] d);
		logic [9:0] q;
		host.xfer(1'b0, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [9:0] exp);
		logic [9:0] q;
		host.xfer(1'b1, a, 10'h000, q);
		chk(20'(q), 20'(exp));
	endtask
	task automatic t_reset();
		chk(frac_divide_word, 20'h55555);
		chk(20'(int_divide_ratio), 20'h74);
		rd(5'h1b, 10'h155);
		rd(5'h1c, 10'h274);
		rd(5'h1d, 10'h000);
		rd(5'h1e, 10'h15f);
		rd(5'h1f, 10'h000);
	endtask
	task automatic t_commit();
		s = n_start;
		wr(5'h1c, 10'h2ab);
		wr(5'h1b, 10'h3c1);
		chk(20'(int_divide_ratio), 20'h74);
		chk(frac_divide_word, 20'h55555);
		wr(5'h1a, 10'h00f);
		chk(frac_divide_word, 20'hf040f);
		chk(20'(int_divide_ratio), 20'hab);
		chk(20'(n_start - s), 20'h1);
	endtask
	task automatic t_no_trig();
		s = n_start;
		wr(5'h1c, 10'h0ac);
		wr(5'h1a, 10'h123);
		chk(20'(n_start - s), 20'h0);
		chk(20'(autoselect_trigger_en), 20'h0);
		chk(20'(int_divide_ratio), 20'hac);
		chk(frac_divide_word, 20'hf0523);
	endtask
	task automatic t_osc();
		wr(5'h1d, 10'h0e5);
		chk(20'(osc_tune_code), 20'he5);
		chk(20'(dac_current_code), 20'h0);
		wr(5'h00, 10'h200);
		chk(20'(bank_sel), 20'h1);
		wr(5'h09, 10'h100);
		wr(5'h1d, 10'h0ff);
		wr(5'h00, 10'h000);
		chk(20'(osc_dac_en), 20'h1);
		chk(20'(dac_current_code), 20'h25);
		chk(20'(osc_tune_code), 20'h0);
		chk(20'(bank_sel), 20'h0);
		rd(5'h1d, 10'h0e5);
	endtask
	task automatic t_band();
		wr(5'h1e, 10'h2a5);
		chk(20'({lo_sub_band, relock_start_sel, band_source_sel, band_override}), 20'h2a5);
		chk(20'(relock_start_sel), 20'h1);
		chk(20'(vco_band_sel), 20'h25);
		rd(5'h1e, 10'h2a5);
		autoselect_adc_result = 3'h5;
		vco_band_switch = 6'h1c;
		wr(5'h00, 10'h200);
		wr(5'h10, 10'h200);
		wr(5'h00, 10'h000);
		chk(20'(band_readout_sel), 20'h1);
		rd(5'h1e, 10'h15c);
		wr(5'h1e, 10'h140);
		chk(20'(vco_band_sel), 20'h1c);
	endtask
	task automatic t_rereset();
		reset_n = 1'b0;
		repeat (12) @(negedge mclk);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk(frac_divide_word, 20'h55555);
		chk(20'({autoselect_trigger_en, int_divide_ratio}), 20'h274);
		chk(20'({bank_sel, osc_dac_en, band_readout_sel}), 20'h0);
		chk(20'(vco_band_sel), 20'h1c);
		rd(5'h1a, 10'h155);
		rd(5'h1e, 10'h15f);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge mclk);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		t_reset();
		t_commit();
		t_no_trig();
		t_osc();
		t_band();
		t_rereset();
		print_verdict();
	end
	// About 25 frames of 7 us each fit well inside this
	initial begin
		#1000000;
		n_fail++;
		print_verdict();
	end
endmodule // tb
bind synth_divider_vco_band_regs regs_properties chk_i (.mclk, .reset_n, .cs_n, .dout, .dout_oe, .vco_band_switch,
	.frac_divide_word, .int_divide_ratio, .autoselect_trigger_en, .autoselect_start, .osc_dac_en, .osc_tune_code,
	.dac_current_code, .lo_sub_band, .relock_start_sel, .band_source_sel, .band_override, .vco_band_sel);
